// ### hdl/gpio_port_pkg.sv
package gpio_port_pkg;

	// bus geometry
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int IDX_W = 16;
	// byte address = register index * 4
	localparam int IDX_LSB = 2;

	// register indices
	localparam logic [IDX_W-1:0] IDX_PIN_LEVEL = 16'hf248;
	localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION = 16'hf249;
	localparam logic [IDX_W-1:0] IDX_DRIVE_MODE_LOW = 16'hf24a;
	localparam logic [IDX_W-1:0] IDX_DRIVE_MODE_HIGH = 16'hf24b;
	localparam logic [IDX_W-1:0] IDX_PIN_BIT_OP = 16'hf24c;

	// reset values
	localparam logic [BYTE_W-1:0] PIN_LEVEL_RST = 8'h00;
	localparam logic [BYTE_W-1:0] PIN_DIRECTION_RST = 8'h00;
	localparam logic [BYTE_W-1:0] DRIVE_MODE_LOW_RST = 8'h00;
	localparam logic [BYTE_W-1:0] DRIVE_MODE_HIGH_RST = 8'h00;

	// bit-operation register fields
	localparam int BITOP_IDX_LSB = 0;
	localparam int BITOP_IDX_W = 3;
	localparam int BITOP_VAL_BIT = 3;

	// upper byte of a 16-bit drive-mode word
	localparam int HALF_HI_LSB = 8;

	// direction and drive codes
	localparam logic DIR_OUTPUT = 1'b0;
	localparam logic DIR_INPUT = 1'b1;
	localparam logic [1:0] DRV_HIZ = 2'h0;
	localparam logic [1:0] DRV_PCH_OD = 2'h1;
	localparam logic [1:0] DRV_NCH_OD = 2'h2;
	localparam logic [1:0] DRV_CMOS = 2'h3;

	// ahb-lite encodings
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int HTRANS_ACTIVE_BIT = 1;

	typedef enum logic [2:0] {
		PH_IDLE = 3'h1,
		PH_WRITE = 3'h2,
		PH_READ = 3'h4
	} phase_t;

endpackage

// ### hdl/gpio_pad_ctrl.sv
`timescale 1ns/1ps
module gpio_pad_ctrl #(
	parameter int PIN_COUNT = 7
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// configuration
	input wire logic [PIN_COUNT-1:0] level,
	input wire logic [PIN_COUNT-1:0] direction,
	input wire logic [PIN_COUNT-1:0] drive_sel_low,
	input wire logic [PIN_COUNT-1:0] drive_sel_high,
	// pad controls
	output logic [PIN_COUNT-1:0] pin_out,
	output logic [PIN_COUNT-1:0] pin_oe,
	output logic [PIN_COUNT-1:0] pin_pull_up,
	output logic [PIN_COUNT-1:0] pin_pull_down
);

	logic [PIN_COUNT-1:0] out_ff, oe_ff, pu_ff, pd_ff;
	logic [PIN_COUNT-1:0] nxt_out, nxt_oe, nxt_pu, nxt_pd;

	always_comb begin
		nxt_out = '0;
		nxt_oe = '0;
		nxt_pu = '0;
		nxt_pd = '0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (direction[i] == gpio_port_pkg::DIR_OUTPUT) begin
				case ({drive_sel_high[i], drive_sel_low[i]})
					gpio_port_pkg::DRV_PCH_OD: begin
						// only the high side may drive
						nxt_out[i] = 1'b1;
						nxt_oe[i] = level[i];
					end
					gpio_port_pkg::DRV_NCH_OD: begin
						// only the low side may drive
						nxt_out[i] = 1'b0;
						nxt_oe[i] = ~level[i];
					end
					gpio_port_pkg::DRV_CMOS: begin
						nxt_out[i] = level[i];
						nxt_oe[i] = 1'b1;
					end
					default: begin
						// both drivers off
						nxt_oe[i] = 1'b0;
					end
				endcase
			end else begin
				// input pins never drive, whatever the stored level
				case ({drive_sel_high[i], drive_sel_low[i]})
					gpio_port_pkg::DRV_PCH_OD: nxt_pd[i] = 1'b1;
					gpio_port_pkg::DRV_NCH_OD: nxt_pu[i] = 1'b1;
					default: nxt_pu[i] = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_ff <= '0;
			oe_ff <= '0;
			pu_ff <= '0;
			pd_ff <= '0;
		end else begin
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
			pu_ff <= nxt_pu;
			pd_ff <= nxt_pd;
		end
	end

	assign pin_out = out_ff;
	assign pin_oe = oe_ff;
	assign pin_pull_up = pu_ff;
	assign pin_pull_down = pd_ff;

endmodule

// ### hdl/seven_bit_gpio_port.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module seven_bit_gpio_port #(
	parameter int PIN_COUNT = 7
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [gpio_port_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [gpio_port_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [gpio_port_pkg::DATA_W-1:0] hrdata,
	// pins
	input wire logic [PIN_COUNT-1:0] pin_in,
	output logic [PIN_COUNT-1:0] pin_out,
	output logic [PIN_COUNT-1:0] pin_oe,
	output logic [PIN_COUNT-1:0] pin_pull_up,
	output logic [PIN_COUNT-1:0] pin_pull_down
);

	localparam int BW = gpio_port_pkg::BYTE_W;
	localparam int DW = gpio_port_pkg::DATA_W;
	localparam int AW = gpio_port_pkg::ADDR_W;
	localparam logic [BW:0] ONE_WIDE = 9'h001;
	// implemented pin bits only; 1 to 8 pins
	localparam logic [BW-1:0] PIN_MASK = BW'((ONE_WIDE << PIN_COUNT) - ONE_WIDE);

	// register state
	logic [BW-1:0] level_ff, nxt_level;
	logic [BW-1:0] dir_ff, nxt_dir;
	logic [BW-1:0] drv_lo_ff, nxt_drv_lo;
	logic [BW-1:0] drv_hi_ff, nxt_drv_hi;
	// bus state
	gpio_port_pkg::phase_t phase_ff, nxt_phase;
	logic [AW-1:0] addr_ff, nxt_addr;
	logic [2:0] size_ff, nxt_size;
	logic [DW-1:0] rdata_ff, nxt_rdata;
	logic ready_ff, nxt_ready;

	logic [BW-1:0] pin_byte;

	assign pin_byte = BW'(pin_in);

	function automatic logic addr_hit(input logic [AW-1:0] addr,
		input logic [gpio_port_pkg::IDX_W-1:0] idx);
		addr_hit = (addr == (AW'(idx) << gpio_port_pkg::IDX_LSB));
	endfunction

	// stored level for outputs, live pin for inputs
	function automatic logic [BW-1:0] readback(input logic [BW-1:0] lvl,
		input logic [BW-1:0] dir, input logic [BW-1:0] pins);
		readback = ((lvl & ~dir) | (pins & dir)) & PIN_MASK;
	endfunction

	localparam int SW = gpio_port_pkg::BITOP_IDX_W;
	localparam int LOW_LSB = 0;
	localparam logic READY_RST = 1'b1;
	// response state
	logic resp_ff, nxt_resp;
	// decoded write strobes
	logic take;
	logic take_read;
	logic wr_level;
	logic wr_dir;
	logic wr_drv_lo;
	logic wr_drv_hi;
	logic wr_bit_op;
	logic wr_wide;
	logic [BW-1:0] wr_byte;
	logic [BW-1:0] wr_upper;
	logic [SW-1:0] op_idx;
	logic op_val;
	logic [BW-1:0] rmw_base;
	// decoded read selects
	logic rd_level;
	logic rd_dir;
	logic rd_drv_lo;
	logic rd_drv_hi;
	logic rd_wide;

	// byte lane of the write data, cut to the implemented pins
	function automatic logic [BW-1:0] lane(input logic [DW-1:0] data, input int lsb);
		lane = data[lsb +: BW] & PIN_MASK;
	endfunction

	// pin index inside the implemented range
	function automatic logic pin_hit(input logic [SW-1:0] idx);
		pin_hit = (32'(idx) < PIN_COUNT);
	endfunction

	// one bit replaced, the rest taken from the read-back byte
	function automatic logic [BW-1:0] bit_update(input logic [BW-1:0] base,
		input logic [SW-1:0] idx, input logic val);
		logic [BW-1:0] upd;
		upd = base;
		upd[idx] = val;
		bit_update = upd & PIN_MASK;
	endfunction

	// drive-mode read: one byte, or both registers as one half-word
	function automatic logic [DW-1:0] drive_word(input logic [BW-1:0] hi,
		input logic [BW-1:0] lo, input logic wide);
		if (wide) begin
			drive_word = DW'({hi, lo});
		end else begin
			drive_word = DW'(lo);
		end
	endfunction

	assign take = hsel & hready & htrans[gpio_port_pkg::HTRANS_ACTIVE_BIT];
	assign take_read = take & ~hwrite;

	// address phase: remember where the data phase goes
	always_comb begin
		nxt_phase = gpio_port_pkg::PH_IDLE;
		nxt_addr = addr_ff;
		nxt_size = size_ff;
		if (take) begin
			nxt_addr = haddr;
			nxt_size = hsize;
			if (hwrite) begin
				nxt_phase = gpio_port_pkg::PH_WRITE;
			end else begin
				nxt_phase = gpio_port_pkg::PH_READ;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ff <= gpio_port_pkg::PH_IDLE;
			addr_ff <= '0;
			size_ff <= '0;
		end else begin
			phase_ff <= nxt_phase;
			addr_ff <= nxt_addr;
			size_ff <= nxt_size;
		end
	end

	// data phase of a write: which register takes hwdata
	always_comb begin
		wr_level = 1'b0;
		wr_dir = 1'b0;
		wr_drv_lo = 1'b0;
		wr_drv_hi = 1'b0;
		wr_bit_op = 1'b0;
		wr_wide = 1'b0;
		wr_byte = lane(hwdata, LOW_LSB);
		wr_upper = lane(hwdata, gpio_port_pkg::HALF_HI_LSB);
		op_idx = hwdata[gpio_port_pkg::BITOP_IDX_LSB +: SW];
		op_val = hwdata[gpio_port_pkg::BITOP_VAL_BIT];
		case (phase_ff)
			gpio_port_pkg::PH_WRITE: begin
				wr_level = addr_hit(addr_ff, gpio_port_pkg::IDX_PIN_LEVEL);
				wr_dir = addr_hit(addr_ff, gpio_port_pkg::IDX_PIN_DIRECTION);
				wr_drv_lo = addr_hit(addr_ff, gpio_port_pkg::IDX_DRIVE_MODE_LOW);
				wr_drv_hi = addr_hit(addr_ff, gpio_port_pkg::IDX_DRIVE_MODE_HIGH);
				wr_bit_op = addr_hit(addr_ff, gpio_port_pkg::IDX_PIN_BIT_OP);
				wr_wide = (size_ff != gpio_port_pkg::HSIZE_BYTE);
			end
			gpio_port_pkg::PH_READ: begin
				wr_wide = 1'b0;
			end
			gpio_port_pkg::PH_IDLE: begin
				wr_wide = 1'b0;
			end
			default: begin
				wr_wide = 1'b0;
			end
		endcase
	end

	// read-modify-write base: input bits take the sampled pin level
	assign rmw_base = readback(level_ff, dir_ff, pin_byte);

	always_comb begin
		nxt_level = level_ff;
		if (wr_level) begin
			// stored for input pins too; pads ignore it there
			nxt_level = wr_byte;
		end
		if (wr_bit_op && pin_hit(op_idx)) begin
			nxt_level = bit_update(rmw_base, op_idx, op_val);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_ff <= gpio_port_pkg::PIN_LEVEL_RST;
		end else begin
			level_ff <= nxt_level;
		end
	end

	always_comb begin
		nxt_dir = dir_ff;
		if (wr_dir) begin
			nxt_dir = wr_byte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_ff <= gpio_port_pkg::PIN_DIRECTION_RST;
		end else begin
			dir_ff <= nxt_dir;
		end
	end

	always_comb begin
		nxt_drv_lo = drv_lo_ff;
		nxt_drv_hi = drv_hi_ff;
		if (wr_drv_lo) begin
			nxt_drv_lo = wr_byte;
			if (wr_wide) begin
				nxt_drv_hi = wr_upper;
			end
		end
		if (wr_drv_hi) begin
			// byte register: upper lanes ignored
			nxt_drv_hi = wr_byte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drv_lo_ff <= gpio_port_pkg::DRIVE_MODE_LOW_RST;
			drv_hi_ff <= gpio_port_pkg::DRIVE_MODE_HIGH_RST;
		end else begin
			drv_lo_ff <= nxt_drv_lo;
			drv_hi_ff <= nxt_drv_hi;
		end
	end

	// address phase of a read: which register answers
	always_comb begin
		rd_level = 1'b0;
		rd_dir = 1'b0;
		rd_drv_lo = 1'b0;
		rd_drv_hi = 1'b0;
		rd_wide = 1'b0;
		if (take_read) begin
			rd_level = addr_hit(haddr, gpio_port_pkg::IDX_PIN_LEVEL);
			rd_dir = addr_hit(haddr, gpio_port_pkg::IDX_PIN_DIRECTION);
			rd_drv_lo = addr_hit(haddr, gpio_port_pkg::IDX_DRIVE_MODE_LOW);
			rd_drv_hi = addr_hit(haddr, gpio_port_pkg::IDX_DRIVE_MODE_HIGH);
			rd_wide = (hsize != gpio_port_pkg::HSIZE_BYTE);
		end
	end

	// read data fetched in the address phase, after any write in flight
	always_comb begin
		nxt_rdata = rdata_ff;
		if (take_read) begin
			// unmapped or misaligned addresses read zero
			nxt_rdata = '0;
			if (rd_level) begin
				nxt_rdata = DW'(readback(nxt_level, nxt_dir, pin_byte));
			end
			if (rd_dir) begin
				nxt_rdata = DW'(nxt_dir & PIN_MASK);
			end
			if (rd_drv_lo) begin
				nxt_rdata = drive_word(nxt_drv_hi, nxt_drv_lo, rd_wide);
			end
			if (rd_drv_hi) begin
				nxt_rdata = DW'(nxt_drv_hi);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// zero wait states
	always_comb begin
		nxt_ready = READY_RST;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_ff <= READY_RST;
		end else begin
			ready_ff <= nxt_ready;
		end
	end

	// never an error response
	always_comb begin
		nxt_resp = gpio_port_pkg::HRESP_OKAY;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_ff <= gpio_port_pkg::HRESP_OKAY;
		end else begin
			resp_ff <= nxt_resp;
		end
	end

	assign hreadyout = ready_ff;
	assign hresp = resp_ff;
	assign hrdata = rdata_ff;

	gpio_pad_ctrl #(
		.PIN_COUNT(PIN_COUNT)
	) u_pad (
		.hclk(hclk),
		.hresetn(hresetn),
		.level(level_ff[PIN_COUNT-1:0]),
		.direction(dir_ff[PIN_COUNT-1:0]),
		.drive_sel_low(drv_lo_ff[PIN_COUNT-1:0]),
		.drive_sel_high(drv_hi_ff[PIN_COUNT-1:0]),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_pull_up(pin_pull_up),
		.pin_pull_down(pin_pull_down)
	);

endmodule

// ### bench/gpio_pin_model.sv
`timescale 1ns/1ps
module gpio_pin_model #(
	parameter int PIN_COUNT = 7
) (
	// pad controls from the port
	input wire logic [PIN_COUNT-1:0] pin_out,
	input wire logic [PIN_COUNT-1:0] pin_oe,
	input wire logic [PIN_COUNT-1:0] pin_pull_up,
	input wire logic [PIN_COUNT-1:0] pin_pull_down,
	// board-side driver
	input wire logic [PIN_COUNT-1:0] ext_level,
	input wire logic [PIN_COUNT-1:0] ext_drive,
	// resolved pin level
	output logic [PIN_COUNT-1:0] pin_in
);
	// a floating pin shows the inverse of the board level, never a stale copy
	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drive[i] ? ext_level[i] :
				pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : ~ext_level[i];
		end
	end
endmodule

// ### bench/seven_bit_gpio_port_checker.sv
`timescale 1ns/1ps
module seven_bit_gpio_port_checker #(
	parameter int PIN_COUNT = 7
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// pins
	input wire logic [PIN_COUNT-1:0] pin_in,
	input wire logic [PIN_COUNT-1:0] pin_out,
	input wire logic [PIN_COUNT-1:0] pin_oe,
	input wire logic [PIN_COUNT-1:0] pin_pull_up,
	input wire logic [PIN_COUNT-1:0] pin_pull_down
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd;
	logic wdir_ff, nxt_wdir;
	logic [PIN_COUNT-1:0] dir_ff, nxt_dir;
	assign rd = hsel & hready & htrans[1] & !hwrite;
	// shadow of the direction register, built from bus writes
	always_comb begin
		nxt_wdir = hsel & hready & htrans[1] & hwrite & (haddr == 32'h0003c924);
		nxt_dir = wdir_ff ? hwdata[PIN_COUNT-1:0] : dir_ff;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdir_ff <= 1'b0;
			dir_ff <= '0;
		end else begin
			wdir_ff <= nxt_wdir;
			dir_ff <= nxt_dir;
		end
	end
	property p_ready;
		hreadyout;
	endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low");
	property p_okay;
		hresp == gpio_port_pkg::HRESP_OKAY;
	endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	property p_quiet;
		$rose(hresetn) |-> (pin_oe | pin_pull_up | pin_pull_down) == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("pad active after reset");
	property p_pulls;
		(pin_pull_up & pin_pull_down) == '0;
	endproperty
	a_pulls: assert property (p_pulls) else $error("both pulls on");
	property p_oe_pull;
		(pin_oe & (pin_pull_up | pin_pull_down)) == '0;
	endproperty
	a_oe_pull: assert property (p_oe_pull) else $error("pull on driven pin");
	property p_bit7;
		rd && (haddr == 32'h0003c920 || haddr == 32'h0003c924) |=> hrdata[7] == 1'b0;
	endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 reads one");
	property p_unmapped;
		rd && !(haddr inside {32'h0003c920, 32'h0003c924, 32'h0003c928, 32'h0003c92c})
			|=> hrdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_live;
		rd && haddr == 32'h0003c920 |=>
			(hrdata[PIN_COUNT-1:0] & dir_ff) == ($past(pin_in) & dir_ff);
	endproperty
	a_live: assert property (p_live) else $error("input pin not read live");
	property p_in_hiz;
		(pin_oe & dir_ff & $past(dir_ff)) == '0;
	endproperty
	a_in_hiz: assert property (p_in_hiz) else $error("input pin driven");
endmodule
bind seven_bit_gpio_port seven_bit_gpio_port_checker #(.PIN_COUNT(PIN_COUNT))
	i_seven_bit_gpio_port_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
	.pin_pull_down(pin_pull_down));

// ### bench/seven_bit_gpio_port_tb_top.sv
`timescale 1ns/1ps
module seven_bit_gpio_port_tb_top;
	localparam int N = 7;
	localparam logic [31:0] A_LVL = 32'h0003c920;
	localparam logic [31:0] A_DIR = 32'h0003c924;
	localparam logic [31:0] A_LO = 32'h0003c928;
	localparam logic [31:0] A_HI = 32'h0003c92c;
	localparam logic [31:0] A_BIT = 32'h0003c930;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp;
	logic [31:0] hrdata, rd;
	logic [N-1:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
	logic [N-1:0] ext_level = '0;
	logic [N-1:0] ext_drive = '0;
	logic [N-1:0] lvl, dir, c0, c1, oe, o, u, p, pv;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	integer seed = 32'h3bfa;
	always #20 hclk = ~hclk;
	seven_bit_gpio_port #(.PIN_COUNT(N)) i_seven_bit_gpio_port (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down));
	gpio_pin_model #(.PIN_COUNT(N)) i_gpio_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_level(ext_level),
		.ext_drive(ext_drive), .pin_in(pin_in));
	task automatic print_verdict();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one single transfer; read data lands in rd
	task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
		input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		hsize <= s;
		htrans <= 2'h2;
		hsel <= 1'b1;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	// expected pad controls from level, direction and drive codes
	function automatic void pads(input logic [N-1:0] l, d, a, b);
		for (int i = 0; i < N; i++) begin
			{oe[i], o[i]} = d[i] ? 2'b00 : (a[i] & b[i]) ? {1'b1, l[i]} :
				b[i] ? {~l[i], 1'b0} : a[i] ? {l[i], 1'b1} : 2'b00;
			u[i] = d[i] & b[i] & ~a[i];
			p[i] = d[i] & a[i] & ~b[i];
		end
	endfunction
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		chk("oe at reset", pin_oe, 0);
		for (int k = 0; k < 4; k++) begin
			xfer(A_LVL + 32'(k * 4), 1'b0, 3'h2, 0);
			chk("reset value", rd, 0);
		end
		xfer(A_BIT + 32'h4, 1'b0, 3'h2, 0);
		chk("unmapped", rd, 0);
		xfer(A_LVL + 32'h1, 1'b0, 3'h2, 0);
		chk("misaligned", rd, 0);
		for (int k = 0; k < 24; k++) begin
			{lvl, dir, c0, c1} = 28'($random(seed));
			if (k < 2) begin
				{dir, c0, c1} = {{N{k[0]}}, {2 * N{1'b1}}};
			end
			{ext_level, ext_drive} <= 14'($random(seed));
			if (k[0]) begin
				xfer(A_LO, 1'b1, 3'h0, {24'h0, 1'b1, c0});
				xfer(A_HI, 1'b1, 3'h0, {24'h0, 1'b1, c1});
			end else begin
				xfer(A_LO, 1'b1, 3'h1, {16'h0, 1'b1, c1, 1'b1, c0});
			end
			xfer(A_LVL, 1'b1, 3'h0, {24'h0, 1'b1, lvl});
			xfer(A_DIR, 1'b1, 3'h0, {24'h0, 1'b1, dir});
			repeat (2) @(posedge hclk);
			#1;
			pads(lvl, dir, c0, c1);
			chk("pin_oe", pin_oe, oe);
			chk("pin_out", pin_out & pin_oe, o & oe);
			chk("pulls", {pin_pull_up, pin_pull_down}, {u, p});
			pv = (oe & o) | (~oe & ((ext_drive & ext_level) | (~ext_drive & (u | (~p & ~ext_level)))));
			@(posedge hclk);
			xfer(A_LVL, 1'b0, 3'h2, 0);
			chk("pin_level", rd, (lvl & ~dir) | (pv & dir));
			xfer(A_DIR, 1'b0, 3'h2, 0);
			chk("pin_direction", rd, dir);
			xfer(A_LO, 1'b0, 3'h1, 0);
			chk("drive word", rd, {16'h0, 1'b0, c1, 1'b0, c0});
			xfer(A_HI, 1'b0, 3'h0, 0);
			chk("drive_mode_high", rd, c1);
		end
		xfer(A_LO, 1'b1, 3'h1, 0);
		ext_drive <= '1;
		ext_level <= 7'h55;
		xfer(A_LVL, 1'b1, 3'h0, 0);
		xfer(A_DIR, 1'b1, 3'h0, 32'h0f);
		xfer(A_BIT, 1'b1, 3'h0, 32'h0d);
		xfer(A_BIT, 1'b1, 3'h0, 32'h0f);
		xfer(A_DIR, 1'b1, 3'h0, 0);
		xfer(A_LVL, 1'b0, 3'h2, 0);
		chk("bit update", rd, 32'h25);
		print_verdict();
	end
endmodule
